// ### hw/cpu_operand_decode_move.sv
// move, exchange and operand decode core with a wishbone register port
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
module cpu_operand_decode_move #(
	parameter int MEM_AW = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// core state
	output logic busy,
	output logic cpu_tick
);

////////////////////////////////////////////////////////////////////////////
// state and decode

logic [7:0] gpr [8];
logic [7:0] mem [2**MEM_AW];
logic [15:0] pair [4];
logic [7:0] program_status_word;
logic [7:0] saved_psw;
logic nonmaskable_active_flag;
logic [15:0] program_counter;
logic [15:0] operand;
logic [15:0] eaddr;
logic [2:0] cpu_clock_select;
logic addr_fault;
logic align_fault;
logic [6:0] div_cnt;
logic [6:0] div_lim;
logic [3:0] busy_cnt;
logic req;
logic wr;
logic go;
logic clr_addr;
logic clr_align;
cpu_move_pkg::cmd_t cmd;
logic [15:0] ea;
logic [15:0] tab;
logic [MEM_AW-1:0] idx;
logic [MEM_AW-1:0] tidx;
logic [7:0] mrd;
logic [7:0] mrd_hi;
logic [15:0] tab_word;
logic mem_op;
logic word_op;
logic bad_addr;
logic bad_align;
logic fault;
logic mem_we;
logic [7:0] reg_val;

function automatic logic in_saddr(input logic [15:0] a);
	in_saddr = (a >= cpu_move_pkg::SADDR_LO) && (a <= cpu_move_pkg::SADDR_HI);
endfunction

// pc after the branch plus sign-extended displacement
function automatic logic [15:0] rel_target(input logic [15:0] pc,
		input logic [7:0] disp);
	rel_target = pc + cpu_move_pkg::LEN_BRANCH + {{8{disp[7]}}, disp};
endfunction

function automatic logic [3:0] instr_cycles(input cpu_move_pkg::cmd_t c);
	case (c.op)
	cpu_move_pkg::OP_NOP, cpu_move_pkg::OP_CY:
		instr_cycles = cpu_move_pkg::CYC_2;
	cpu_move_pkg::OP_MOV_A_R, cpu_move_pkg::OP_MOV_R_A,
	cpu_move_pkg::OP_MOV_A_PSW, cpu_move_pkg::OP_BIT_A:
		instr_cycles = cpu_move_pkg::CYC_4;
	cpu_move_pkg::OP_MOV_A_MEM, cpu_move_pkg::OP_MOV_MEM_A:
		instr_cycles = (c.mode == cpu_move_pkg::M_SADDR) ?
			cpu_move_pkg::CYC_4 : ((c.mode == cpu_move_pkg::M_ABS) ?
			cpu_move_pkg::CYC_8 : cpu_move_pkg::CYC_6);
	cpu_move_pkg::OP_XCH_A_R:
		instr_cycles = (c.reg_idx == cpu_move_pkg::IDX_X) ?
			cpu_move_pkg::CYC_4 : cpu_move_pkg::CYC_6;
	cpu_move_pkg::OP_XCH_A_MEM:
		instr_cycles = (c.mode == cpu_move_pkg::M_SADDR) ?
			cpu_move_pkg::CYC_6 : cpu_move_pkg::CYC_8;
	cpu_move_pkg::OP_CALLT:
		instr_cycles = cpu_move_pkg::CYC_8;
	default:
		instr_cycles = cpu_move_pkg::CYC_6;
	endcase
endfunction

// high byte at odd index, low byte at even index
for (genvar p = 0; p < 4; p++) begin : g_pair
	assign pair[p] = {gpr[2*p+1], gpr[2*p]};
end

assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr = req & wb_we_i & wb_sel_i[0];
assign go = wr & (wb_adr_i == cpu_move_pkg::OFS_COMMAND) & ~busy;
assign cmd = cpu_move_pkg::cmd_t'(wb_dat_i[14:0]);
assign reg_val = gpr[cmd.reg_idx];
assign busy = (busy_cnt != 4'h0);
assign clr_addr = wr & (wb_adr_i == cpu_move_pkg::OFS_STATUS)
	& wb_dat_i[cpu_move_pkg::ST_ADDR_FAULT];
assign clr_align = wr & (wb_adr_i == cpu_move_pkg::OFS_STATUS)
	& wb_dat_i[cpu_move_pkg::ST_ALIGN_FAULT];

// effective address from the operand mode
always_comb begin
	case (cmd.mode)
	cpu_move_pkg::M_SADDR, cpu_move_pkg::M_ABS:
		ea = operand;
	cpu_move_pkg::M_DE:
		ea = pair[cpu_move_pkg::PAIR_DE];
	cpu_move_pkg::M_HL:
		ea = pair[cpu_move_pkg::PAIR_HL];
	cpu_move_pkg::M_HL_OFS:
		ea = pair[cpu_move_pkg::PAIR_HL] + {8'h00, operand[7:0]};
	default:
		ea = operand;
	endcase
end

// vector entry is always even and inside the call table
assign tab = cpu_move_pkg::TABLE_BASE + {10'h000, operand[4:0], 1'b0};
assign idx = ea[MEM_AW-1:0];
assign tidx = tab[MEM_AW-1:0];
assign mrd = mem[idx];
assign mrd_hi = mem[idx + 1'b1];
assign tab_word = {mem[tidx + 1'b1], mem[tidx]};

// short direct window and word alignment checks
assign word_op = (cmd.op == cpu_move_pkg::OP_MOVW_AX_MEM);
assign mem_op = word_op || (cmd.op == cpu_move_pkg::OP_MOV_A_MEM)
	|| (cmd.op == cpu_move_pkg::OP_MOV_MEM_A)
	|| (cmd.op == cpu_move_pkg::OP_XCH_A_MEM);
assign bad_addr = (cmd.mode == cpu_move_pkg::M_SADDR) && !in_saddr(ea)
	|| (cmd.mode > cpu_move_pkg::M_HL_OFS)
	|| word_op && (cmd.mode > cpu_move_pkg::M_ABS);
assign bad_align = word_op && ea[0];
assign fault = mem_op && (bad_addr || bad_align);
assign mem_we = go && !fault && ((cmd.op == cpu_move_pkg::OP_MOV_MEM_A)
	|| (cmd.op == cpu_move_pkg::OP_XCH_A_MEM));

////////////////////////////////////////////////////////////////////////////
// cpu clock divider and instruction timing

// divide by two to the power of the clock select
assign div_lim = (7'h01 << cpu_clock_select) - 7'h01;
assign cpu_tick = (div_cnt == div_lim);

// divider restarts at each instruction so its length is exact
always_ff @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		div_cnt <= 7'h00;
	end else if (go || cpu_tick) begin
		div_cnt <= 7'h00;
	end else begin
		div_cnt <= div_cnt + 7'h01;
	end
end

// busy for the instruction's count of cpu clocks
always_ff @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		busy_cnt <= 4'h0;
	end else if (go) begin
		busy_cnt <= instr_cycles(cmd);
	end else if (cpu_tick && busy) begin
		busy_cnt <= busy_cnt - 4'h1;
	end
end

////////////////////////////////////////////////////////////////////////////
// data memory, not reset: contents are undefined at power-up

always_ff @(posedge clk) begin
	if (mem_we) begin
		mem[idx] <= gpr[cpu_move_pkg::IDX_A];
	end
end

////////////////////////////////////////////////////////////////////////////
// architectural registers

// registers, pc and effective address capture
always_ff @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		for (int i = 0; i < 8; i++) begin
			gpr[i] <= 8'h00;
		end
		program_counter <= cpu_move_pkg::PC_RESET;
		eaddr <= 16'h0000;
	end else if (go) begin
		eaddr <= ea;
		case (cmd.op)
		cpu_move_pkg::OP_MOV_R_IMM:
			gpr[cmd.reg_idx] <= operand[7:0];
		cpu_move_pkg::OP_MOV_A_R:
			gpr[cpu_move_pkg::IDX_A] <= reg_val;
		cpu_move_pkg::OP_MOV_R_A:
			gpr[cmd.reg_idx] <= gpr[cpu_move_pkg::IDX_A];
		cpu_move_pkg::OP_MOV_A_MEM:
			if (!fault) begin
				gpr[cpu_move_pkg::IDX_A] <= mrd;
			end
		cpu_move_pkg::OP_MOV_A_PSW:
			gpr[cpu_move_pkg::IDX_A] <= program_status_word;
		cpu_move_pkg::OP_XCH_A_R: begin
			gpr[cpu_move_pkg::IDX_A] <= reg_val;
			gpr[cmd.reg_idx] <= gpr[cpu_move_pkg::IDX_A];
		end
		cpu_move_pkg::OP_XCH_A_MEM:
			if (!fault) begin
				gpr[cpu_move_pkg::IDX_A] <= mrd;
			end
		cpu_move_pkg::OP_MOVW_AX_MEM:
			if (!fault) begin
				gpr[cpu_move_pkg::IDX_A] <= mrd_hi;
				gpr[cpu_move_pkg::IDX_X] <= mrd;
			end
		cpu_move_pkg::OP_BR_REL:
			program_counter <= rel_target(program_counter, operand[7:0]);
		cpu_move_pkg::OP_CALLT:
			program_counter <= tab_word;
		cpu_move_pkg::OP_BIT_A:
			gpr[cpu_move_pkg::IDX_A][cmd.bit_pos] <= cmd.mode[0];
		default: begin
		end
		endcase
	end else if (wr && wb_adr_i == cpu_move_pkg::OFS_PC) begin
		program_counter <= wb_dat_i[15:0];
	end
end

// status word: only status-word writes, carry ops, restores and nonmaskable entry touch it
always_ff @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		program_status_word <= cpu_move_pkg::PSW_RESET;
		saved_psw <= cpu_move_pkg::PSW_RESET;
		nonmaskable_active_flag <= 1'b0;
	end else if (go) begin
		case (cmd.op)
		cpu_move_pkg::OP_MOV_PSW_IMM:
			program_status_word <= operand[7:0];
		cpu_move_pkg::OP_CY:
			case (cpu_move_pkg::flag_act_t'(cmd.mode))
			cpu_move_pkg::F_CLEAR:
				program_status_word[cpu_move_pkg::PSW_CY] <= 1'b0;
			cpu_move_pkg::F_SET:
				program_status_word[cpu_move_pkg::PSW_CY] <= 1'b1;
			cpu_move_pkg::F_DERIVE:
				program_status_word[cpu_move_pkg::PSW_CY] <=
					~program_status_word[cpu_move_pkg::PSW_CY];
			cpu_move_pkg::F_RESTORE:
				program_status_word[cpu_move_pkg::PSW_CY] <=
					saved_psw[cpu_move_pkg::PSW_CY];
			default: begin
			end
			endcase
		cpu_move_pkg::OP_PSW:
			case (cmd.mode)
			3'h0:
				saved_psw <= program_status_word;
			3'h1: begin
				program_status_word <= saved_psw;
				nonmaskable_active_flag <= 1'b0;
			end
			3'h2: begin
				saved_psw <= program_status_word;
				program_status_word[cpu_move_pkg::PSW_IE] <= 1'b0;
				nonmaskable_active_flag <= 1'b1;
			end
			default: begin
			end
			endcase
		default: begin
		end
		endcase
	end else if (wr && wb_adr_i == cpu_move_pkg::OFS_PSW) begin
		program_status_word <= wb_dat_i[7:0];
	end
end

// sticky faults, a new fault wins over a clear in the same cycle
always_ff @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		addr_fault <= 1'b0;
		align_fault <= 1'b0;
	end else begin
		addr_fault <= (go && mem_op && bad_addr) || (addr_fault && !clr_addr);
		align_fault <= (go && bad_align) || (align_fault && !clr_align);
	end
end

////////////////////////////////////////////////////////////////////////////
// wishbone slave: one wait state, unmapped reads return zero

// operand and clock select registers
always_ff @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		operand <= 16'h0000;
		cpu_clock_select <= cpu_move_pkg::CLKSEL_RESET;
	end else if (wr && wb_adr_i == cpu_move_pkg::OFS_OPERAND) begin
		operand <= wb_dat_i[15:0];
	end else if (wr && wb_adr_i == cpu_move_pkg::OFS_CLKSEL) begin
		cpu_clock_select <= wb_dat_i[2:0];
	end
end

// ack and registered read data
always_ff @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0000_0000;
	end else begin
		wb_ack_o <= req;
		wb_dat_o <= 32'h0000_0000;
		if (req && !wb_we_i) begin
			case (wb_adr_i)
			cpu_move_pkg::OFS_OPERAND:
				wb_dat_o <= {16'h0000, operand};
			cpu_move_pkg::OFS_STATUS:
				wb_dat_o <= {28'h0000000, nonmaskable_active_flag,
					align_fault, addr_fault, busy};
			cpu_move_pkg::OFS_PSW:
				wb_dat_o <= {24'h000000, program_status_word};
			cpu_move_pkg::OFS_CLKSEL:
				wb_dat_o <= {29'h00000000, cpu_clock_select};
			cpu_move_pkg::OFS_PAIRS_LO:
				wb_dat_o <= {pair[1], pair[0]};
			cpu_move_pkg::OFS_PAIRS_HI:
				wb_dat_o <= {pair[3], pair[2]};
			cpu_move_pkg::OFS_PC:
				wb_dat_o <= {16'h0000, program_counter};
			cpu_move_pkg::OFS_EADDR:
				wb_dat_o <= {16'h0000, eaddr};
			default:
				wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// assertions

default clocking dc @(posedge clk); endclocking
default disable iff (!rstn);

a_imm_to_reg: assert property (
	go && cmd.op == cpu_move_pkg::OP_MOV_R_IMM
	|=> gpr[$past(cmd.reg_idx)] == $past(operand[7:0]))
	else $error("immediate not in selected register");
a_word_to_ax: assert property (
	go && word_op && !fault
	|=> pair[cpu_move_pkg::PAIR_AX] == $past({mrd_hi, mrd}))
	else $error("word move did not load the word accumulator");
a_saddr_window: assert property (
	go && cmd.op == cpu_move_pkg::OP_MOV_MEM_A
	&& cmd.mode == cpu_move_pkg::M_SADDR && !in_saddr(operand)
	|=> addr_fault && !$past(mem_we))
	else $error("short direct outside window accepted");
a_odd_word: assert property (
	go && word_op && ea[0] |=> align_fault ##1 align_fault)
	else $error("odd word address not flagged");
a_table_call: assert property (
	go && cmd.op == cpu_move_pkg::OP_CALLT
	|=> program_counter == $past(tab_word) && !$past(tab[0]))
	else $error("table call target wrong");
a_branch_target: assert property (
	go && cmd.op == cpu_move_pkg::OP_BR_REL
	|=> program_counter == $past(program_counter) + 16'h0002
	+ {{8{$past(operand[7])}}, $past(operand[7:0])})
	else $error("branch target wrong");
a_bit_select: assert property (
	go && cmd.op == cpu_move_pkg::OP_BIT_A
	|=> gpr[cpu_move_pkg::IDX_A][$past(cmd.bit_pos)] == $past(cmd.mode[0]))
	else $error("bit operand missed");
a_move_flags: assert property (
	go && cmd.op inside {cpu_move_pkg::OP_MOV_A_R, cpu_move_pkg::OP_MOV_R_A,
	cpu_move_pkg::OP_XCH_A_R, cpu_move_pkg::OP_XCH_A_MEM,
	cpu_move_pkg::OP_MOV_A_MEM}
	|=> $stable(program_status_word))
	else $error("move changed flags");
a_psw_restore: assert property (
	go && cmd.op == cpu_move_pkg::OP_PSW && cmd.mode == 3'h1
	|=> program_status_word == $past(saved_psw) && !nonmaskable_active_flag)
	else $error("restore of status word failed");
a_nop_length: assert property (
	go && cmd.op == cpu_move_pkg::OP_NOP && cpu_clock_select == 3'h0
	|=> busy ##1 busy ##1 !busy)
	else $error("nop did not last two cpu clocks");
a_indirect_read: assert property (
	go && cmd.op == cpu_move_pkg::OP_MOV_A_MEM
	&& cmd.mode == cpu_move_pkg::M_HL
	|=> gpr[cpu_move_pkg::IDX_A] == $past(mrd)
	&& eaddr == $past(pair[cpu_move_pkg::PAIR_HL]))
	else $error("indirect read used wrong address");

c_word_move: cover property (go && word_op && !fault);
c_table_call: cover property (go && cmd.op == cpu_move_pkg::OP_CALLT);
c_nmi_enter: cover property (go && cmd.op == cpu_move_pkg::OP_PSW
	&& cmd.mode == 3'h2);
c_refused: cover property (req && busy);

endmodule // cpu_operand_decode_move

// ### common/cpu_move_pkg.sv
// package: register map, operand constants and command layout of the move core
package cpu_move_pkg;
	// wishbone byte offsets
	localparam logic [7:0] OFS_COMMAND = 8'h00;
	localparam logic [7:0] OFS_OPERAND = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_PSW = 8'h0c;
	localparam logic [7:0] OFS_CLKSEL = 8'h10;
	localparam logic [7:0] OFS_PAIRS_LO = 8'h14;
	localparam logic [7:0] OFS_PAIRS_HI = 8'h18;
	localparam logic [7:0] OFS_PC = 8'h1c;
	localparam logic [7:0] OFS_EADDR = 8'h20;
	// absolute register numbering
	localparam logic [2:0] IDX_X = 3'h0;
	localparam logic [2:0] IDX_A = 3'h1;
	localparam logic [1:0] PAIR_AX = 2'h0;
	localparam logic [1:0] PAIR_DE = 2'h2;
	localparam logic [1:0] PAIR_HL = 2'h3;
	// address windows
	localparam logic [15:0] SADDR_LO = 16'hfe20;
	localparam logic [15:0] SADDR_HI = 16'hff1f;
	localparam logic [15:0] TABLE_BASE = 16'h0040;
	// status word bits and reset values
	localparam int PSW_IE = 7;
	localparam int PSW_CY = 0;
	localparam logic [7:0] PSW_RESET = 8'h02;
	localparam logic [2:0] CLKSEL_RESET = 3'h2;
	localparam logic [15:0] PC_RESET = 16'h0000;
	// status register bits
	localparam int ST_BUSY = 0;
	localparam int ST_ADDR_FAULT = 1;
	localparam int ST_ALIGN_FAULT = 2;
	localparam int ST_NMI = 3;
	// instruction lengths and cpu clock counts
	localparam logic [15:0] LEN_BRANCH = 16'h0002;
	localparam logic [3:0] CYC_2 = 4'h2;
	localparam logic [3:0] CYC_4 = 4'h4;
	localparam logic [3:0] CYC_6 = 4'h6;
	localparam logic [3:0] CYC_8 = 4'h8;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_MOV_R_IMM = 4'h1, OP_MOV_A_R = 4'h2,
		OP_MOV_R_A = 4'h3, OP_MOV_A_MEM = 4'h4, OP_MOV_MEM_A = 4'h5,
		OP_MOV_PSW_IMM = 4'h6, OP_MOV_A_PSW = 4'h7, OP_XCH_A_R = 4'h8,
		OP_XCH_A_MEM = 4'h9, OP_MOVW_AX_MEM = 4'ha, OP_BR_REL = 4'hb,
		OP_CALLT = 4'hc, OP_BIT_A = 4'hd, OP_CY = 4'he, OP_PSW = 4'hf
	} op_t;
	typedef enum logic [2:0] {
		M_SADDR = 3'h0, M_ABS = 3'h1, M_DE = 3'h2, M_HL = 3'h3,
		M_HL_OFS = 3'h4
	} mode_t;
	typedef enum logic [2:0] {
		F_KEEP = 3'h0, F_CLEAR = 3'h1, F_SET = 3'h2, F_DERIVE = 3'h3,
		F_RESTORE = 3'h4
	} flag_act_t;
	// command word, op in bits 14:11 down to bit_pos in 2:0
	typedef struct packed {
		op_t op;
		logic [2:0] reg_idx;
		logic [1:0] pair_idx;
		logic [2:0] mode;
		logic [2:0] bit_pos;
	} cmd_t;
endpackage

// ### test/test_cpu_operand_decode_move.sv
// self-checking bench for the operand decode and move core
`timescale 1ns/1ps
module test_cpu_operand_decode_move;
	// clock, reset and wishbone lines driven by the bench
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic busy;
	logic cpu_tick;
	int fail_count = 0;
	int comparisons = 0;
	int busy_cycles = 0;
	// expected general registers, index is the absolute number
	logic [7:0] gpr [8] = '{default: 8'h00};
	logic [15:0] sa [4] = '{16'hfe1f, 16'hfe20, 16'hff1f, 16'hff20};
	logic [7:0] ds [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
	logic [2:0] cm [6] = '{3'h0, 3'h1, 3'h3, 3'h3, 3'h4, 3'h3};

	cpu_operand_decode_move #(.MEM_AW(8)) uut (
		.clk(clk), .rstn(rstn),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.busy(busy), .cpu_tick(cpu_tick)
	);

	always #5 clk = ~clk;

	// counts edges that close a busy cycle, pre-edge value is read
	always @(posedge clk) begin
		if (busy === 1'b1)
			busy_cycles++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] adr,
			input logic [31:0] dat, output logic [31:0] q);
		int n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			fail_count++;
			$display("mismatch wb_ack expected 1 seen 0");
			close_out();
		end
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] q;
		wb(1'b1, adr, dat, q);
	endtask

	task automatic rdc(input string what, input logic [7:0] adr,
			input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, adr, 32'h0, q);
		chk(what, exp, q);
	endtask

	// operand first, then the command, then wait out busy
	task automatic exec(input cpu_move_pkg::op_t op, input logic [2:0] r,
			input logic [2:0] m, input logic [2:0] bp, input logic [15:0] opd);
		int n = 0;
		wr(cpu_move_pkg::OFS_OPERAND, {16'h0, opd});
		busy_cycles = 0;
		wr(cpu_move_pkg::OFS_COMMAND, {17'h0, op, r, 2'h0, m, bp});
		while (busy === 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (busy !== 1'b0) begin
			fail_count++;
			$display("mismatch busy expected 0 seen %b", busy);
			close_out();
		end
	endtask

	task automatic setr(input int i, input logic [7:0] v);
		exec(cpu_move_pkg::OP_MOV_R_IMM, 3'(i), 3'h0, 3'h0, {8'h0, v});
		gpr[i] = v;
	endtask

	task automatic put(input logic [15:0] a, input logic [7:0] v);
		setr(1, v);
		exec(cpu_move_pkg::OP_MOV_MEM_A, 3'h0, cpu_move_pkg::M_ABS, 3'h0, a);
	endtask

	// pair reads hold {bc,ax} and {hl,de}, so byte i is register i
	task automatic chk_regs();
		logic [31:0] lo;
		logic [31:0] hi;
		logic [63:0] all;
		wb(1'b0, cpu_move_pkg::OFS_PAIRS_LO, 32'h0, lo);
		wb(1'b0, cpu_move_pkg::OFS_PAIRS_HI, 32'h0, hi);
		all = {hi, lo};
		for (int i = 0; i < 8; i++)
			chk($sformatf("gpr%0d", i), {24'h0, gpr[i]}, {24'h0, all[8*i+:8]});
	endtask

	function automatic logic next_cy(input logic [2:0] m, input logic c,
			input logic s);
		case (m)
			3'h0: return c;
			3'h1: return 1'b0;
			3'h2: return 1'b1;
			3'h3: return ~c;
			default: return s;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] q;
		logic [15:0] a;
		logic [15:0] p;
		logic [7:0] v;
		logic [7:0] w;
		logic [7:0] d;
		logic cy;
		void'($urandom(31914));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// state after reset, unmapped offset reads zero
		rdc("psw", cpu_move_pkg::OFS_PSW, 32'h2);
		rdc("clksel", cpu_move_pkg::OFS_CLKSEL, 32'h2);
		rdc("status", cpu_move_pkg::OFS_STATUS, 32'h0);
		rdc("pc", cpu_move_pkg::OFS_PC, 32'h0);
		rdc("unmapped", 8'h24, 32'h0);
		$display("test reset done");
		// durations scale with the cpu clock divider
		for (int k = 0; k < 4; k++) begin
			wr(cpu_move_pkg::OFS_CLKSEL, k);
			exec(cpu_move_pkg::OP_NOP, 3'h0, 3'h0, 3'h0, 16'h0);
			chk("nop_len", 2 << k, busy_cycles);
			exec(cpu_move_pkg::OP_MOV_R_IMM, 3'h0, 3'h0, 3'h0, 16'h0);
			chk("imm_len", 6 << k, busy_cycles);
		end
		wr(cpu_move_pkg::OFS_CLKSEL, 32'h0);
		$display("test timing done");
		// numbering, then moves and exchanges that must keep the flags
		for (int i = 0; i < 8; i++)
			setr(i, 8'($urandom));
		chk_regs();
		exec(cpu_move_pkg::OP_MOV_PSW_IMM, 3'h0, 3'h0, 3'h0, 16'h00d1);
		exec(cpu_move_pkg::OP_MOV_A_R, 3'h5, 3'h0, 3'h0, 16'h0);
		gpr[1] = gpr[5];
		exec(cpu_move_pkg::OP_MOV_R_A, 3'h2, 3'h0, 3'h0, 16'h0);
		gpr[2] = gpr[1];
		exec(cpu_move_pkg::OP_XCH_A_R, 3'h0, 3'h0, 3'h0, 16'h0);
		{gpr[0], gpr[1]} = {gpr[1], gpr[0]};
		exec(cpu_move_pkg::OP_XCH_A_R, 3'h7, 3'h0, 3'h0, 16'h0);
		{gpr[7], gpr[1]} = {gpr[1], gpr[7]};
		chk_regs();
		wb(1'b0, cpu_move_pkg::OFS_PSW, 32'h0, q);
		chk("psw_kept", 32'hd1, q & 32'hd1);
		$display("test registers done");
		// every mode stores, then reads back through an absolute address
		for (int m = 0; m < 5; m++) begin
			v = 8'($urandom);
			w = 8'($urandom);
			d = 8'($urandom);
			p = (m == 0) ? 16'hfe20 + {8'h0, d} : {8'h0, d};
			a = (m == 2) ? {gpr[5], gpr[4]} : {gpr[7], gpr[6]};
			a = (m == 4) ? a + {8'h0, d} : (m < 2) ? {d, 8'($urandom)} : a;
			p = (m == 1) ? a : p;
			a = (m == 0) ? p : a; // short direct reads back at its own byte
			setr(1, v);
			exec(cpu_move_pkg::OP_MOV_MEM_A, 3'h0, 3'(m), 3'h0, p);
			setr(1, ~v);
			exec(cpu_move_pkg::OP_MOV_A_MEM, 3'h0, cpu_move_pkg::M_ABS, 3'h0, a);
			gpr[1] = v;
			chk_regs();
			setr(1, w);
			exec(cpu_move_pkg::OP_XCH_A_MEM, 3'h0, 3'(m), 3'h0, p);
			gpr[1] = v;
			chk_regs();
			exec(cpu_move_pkg::OP_MOV_A_MEM, 3'h0, cpu_move_pkg::M_ABS, 3'h0, a);
			gpr[1] = w;
			chk_regs();
		end
		$display("test modes done");
		// short direct window edges, faults leave the registers alone
		for (int j = 0; j < 4; j++) begin
			exec(cpu_move_pkg::OP_MOV_A_MEM, 3'h0, cpu_move_pkg::M_SADDR,
				3'h0, sa[j]);
			rdc("saddr", cpu_move_pkg::OFS_STATUS,
				(j == 0 || j == 3) ? 32'h2 : 32'h0);
			wr(cpu_move_pkg::OFS_STATUS, 32'h6);
			if (j == 0)
				chk_regs();
		end
		// word move into the accumulator pair, odd address refused
		a = {8'($urandom), 7'($urandom), 1'b0};
		v = 8'($urandom);
		w = 8'($urandom);
		put(a, v);
		put(a + 16'h1, w);
		exec(cpu_move_pkg::OP_MOVW_AX_MEM, 3'h0, cpu_move_pkg::M_ABS, 3'h0, a);
		gpr[0] = v;
		gpr[1] = w;
		chk_regs();
		exec(cpu_move_pkg::OP_MOVW_AX_MEM, 3'h0, cpu_move_pkg::M_ABS, 3'h0,
			a | 16'h1);
		rdc("align", cpu_move_pkg::OFS_STATUS, 32'h4);
		chk_regs();
		wr(cpu_move_pkg::OFS_STATUS, 32'h6);
		exec(cpu_move_pkg::OP_MOVW_AX_MEM, 3'h0, cpu_move_pkg::M_SADDR, 3'h0,
			16'hfe21);
		rdc("saddrp", cpu_move_pkg::OFS_STATUS, 32'h4);
		wr(cpu_move_pkg::OFS_STATUS, 32'h6);
		$display("test faults done");
		// signed displacement from the updated counter
		for (int j = 0; j < 8; j++) begin
			d = (j < 4) ? ds[j] : 8'($urandom);
			p = 16'($urandom);
			wr(cpu_move_pkg::OFS_PC, {16'h0, p});
			exec(cpu_move_pkg::OP_BR_REL, 3'h0, 3'h0, 3'h0, {8'h0, d});
			rdc("pc", cpu_move_pkg::OFS_PC,
				{16'h0, p + 16'h2 + {{8{d[7]}}, d}});
		end
		// table call at both ends of the index range
		for (int j = 0; j < 3; j++) begin
			d = (j == 0) ? 8'h00 : (j == 1) ? 8'h1f : 8'($urandom) & 8'h1f;
			a = 16'h0040 + {7'h0, d, 1'b0};
			v = 8'($urandom);
			w = 8'($urandom);
			put(a, v);
			put(a + 16'h1, w);
			exec(cpu_move_pkg::OP_CALLT, 3'h0, 3'h0, 3'h0, {8'h0, d});
			rdc("callt", cpu_move_pkg::OFS_PC, {16'h0, w, v});
		end
		$display("test branches done");
		// each accumulator bit flipped on its own
		for (int j = 0; j < 8; j++) begin
			cy = ~gpr[1][j];
			exec(cpu_move_pkg::OP_BIT_A, 3'h0, {2'h0, cy}, 3'(j), 16'h0);
			gpr[1][j] = cy;
			chk_regs();
		end
		// carry actions, restore comes from the saved status copy
		exec(cpu_move_pkg::OP_CY, 3'h0, 3'h2, 3'h0, 16'h0);
		exec(cpu_move_pkg::OP_PSW, 3'h0, 3'h0, 3'h0, 16'h0);
		cy = 1'b1;
		for (int j = 0; j < 6; j++) begin
			exec(cpu_move_pkg::OP_CY, 3'h0, cm[j], 3'h0, 16'h0);
			cy = next_cy(cm[j], cy, 1'b1);
			wb(1'b0, cpu_move_pkg::OFS_PSW, 32'h0, q);
			chk("carry", {31'h0, cy}, {31'h0, q[cpu_move_pkg::PSW_CY]});
		end
		// nonmaskable entry and return
		exec(cpu_move_pkg::OP_MOV_PSW_IMM, 3'h0, 3'h0, 3'h0, 16'h0081);
		exec(cpu_move_pkg::OP_PSW, 3'h0, 3'h2, 3'h0, 16'h0);
		rdc("nmi_on", cpu_move_pkg::OFS_STATUS, 32'h8);
		wb(1'b0, cpu_move_pkg::OFS_PSW, 32'h0, q);
		chk("ie_off", 32'h0, {31'h0, q[cpu_move_pkg::PSW_IE]});
		exec(cpu_move_pkg::OP_PSW, 3'h0, 3'h1, 3'h0, 16'h0);
		rdc("nmi_off", cpu_move_pkg::OFS_STATUS, 32'h0);
		wb(1'b0, cpu_move_pkg::OFS_PSW, 32'h0, q);
		chk("ie_back", 32'h81, q & 32'h81);
		$display("test flags done");
		close_out();
	end
endmodule // test_cpu_operand_decode_move
